// ---- src/prsc_defs.vh ----
// Constants for the reference skip and ratio control block
`ifndef PRSC_DEFS_VH
`define PRSC_DEFS_VH

// Register byte offsets on the control port
`define PRSC_ADDR_RATIO3 8'h06
`define PRSC_ADDR_RATIO2 8'h07
`define PRSC_ADDR_RATIO1 8'h08
`define PRSC_ADDR_RATIO0 8'h09
`define PRSC_ADDR_CFG 8'h0A
`define PRSC_ADDR_SCALE 8'h0B
`define PRSC_ADDR_STATUS 8'h0C

// Field positions in the configuration byte
`define PRSC_CFG_SKIP_BIT 0
`define PRSC_CFG_OUTUNL_BIT 1
`define PRSC_CFG_FMT_BIT 2
`define PRSC_CFG_BW_LSB 4
`define PRSC_CFG_BW_MSB 6

// Field positions in the scale byte
`define PRSC_SCALE_LSB 0
`define PRSC_SCALE_MSB 2
`define PRSC_SCALE_DIV_BIT 2

// Field positions in the status byte
`define PRSC_STAT_LOCK_BIT 0
`define PRSC_STAT_ACQ_BIT 1
`define PRSC_STAT_LOST_BIT 2

// Reset values
`define PRSC_RATIO_RST 32'h0000_0000
`define PRSC_SKIP_RST 1'b0
`define PRSC_OUTUNL_RST 1'b0
`define PRSC_FMT_RST 1'b0
`define PRSC_BW_RST 3'h0
`define PRSC_SCALE_RST 3'h0

// Timing
`define PRSC_CLK_MHZ 250
`define PRSC_SKIP_WIN_MS 20
`define PRSC_SKIP_MAX_KHZ 80
`define PRSC_TIMEOUT_LCO 8388608
`define PRSC_LCO_DIV_MAX 4'hF
`define PRSC_ACQ_EDGES 4'hF
`define PRSC_GAP_SAT 24'hFF_FFFF

`endif

// ---- src/prsc_ratio_scale.v ----
// Power-of-two ratio modifier forming the effective ratio
`timescale 1ns/1ps
`include "prsc_defs.vh"
module prsc_ratio_scale
(
  input wire [31:0] user_ratio,
  input wire [2:0] ratio_scale_sel,
  output reg [31:0] effective_ratio
);

  // Shifts instead of a multiplier; bits pushed out are lost, software must avoid that
  always @*
  begin
    effective_ratio = user_ratio;
    if (ratio_scale_sel[`PRSC_SCALE_DIV_BIT])
    begin
      case (ratio_scale_sel[1:0])
        2'h0: effective_ratio = {1'b0, user_ratio[31:1]};
        2'h1: effective_ratio = {2'h0, user_ratio[31:2]};
        2'h2: effective_ratio = {3'h0, user_ratio[31:3]};
        default: effective_ratio = {4'h0, user_ratio[31:4]};
      endcase
    end
    else
    begin
      case (ratio_scale_sel[1:0])
        2'h0: effective_ratio = user_ratio;
        2'h1: effective_ratio = {user_ratio[30:0], 1'b0};
        2'h2: effective_ratio = {user_ratio[29:0], 2'h0};
        default: effective_ratio = {user_ratio[28:0], 3'h0};
      endcase
    end
  end

endmodule

// ---- src/prsc_top.v ----
// Reference loss handling, loop bandwidth and ratio control for the clock multiplier
// Notes on behaviour
// - Skip enabled: missing reference pulses up to 20 ms keep the loop locked.
// - Output continues for 2^23 oscillator ticks after the reference stops.
// - A glitch or shortened period means frequency change: unlock at once.
// - Time-out expiry with reference absent declares unlock; output follows unlock setting.
// - Reference back after time-out: stay unlocked while acquiring, then lock.
// - Skip enabled, outage past window but inside time-out: no unlock shown.
// - Skip disabled, short outage: output runs until return, then unlocked while reacquiring.
// - Skip enabled, short outage: output stays continuous through gap and reacquisition.
// - Three-bit field picks minimum loop bandwidth, 1 Hz to 128 Hz.
// - Jitter below the chosen corner passes through unattenuated.
// - Wide bandwidth while acquiring; selected minimum bandwidth once locked.
// - User ratio is a 32-bit unsigned fixed-point register value.
// - Format bit picks 12.20 or 20.12; 20.12 after reset.
// - High-resolution format: 12 integer bits, 20 fraction bits.
// - High-multiplication format: 20 integer bits, 12 fraction bits.
// - Modifier scales the ratio internally; stored register value unchanged.
// - Modifier codes: 1, 2, 4, 8, then 0.5 down to 0.0625; reset 000.
// - Effective ratio is user ratio times modifier, fed to the synthesizer.
// - Unlocked output held low unless output-on-unlock is set.
// - Changing ratio, format or modifier forces loss of lock and reacquisition.
`timescale 1ns/1ps
`include "prsc_defs.vh"
module prsc_top
#(
  parameter integer SKIP_WIN_CYCLES = `PRSC_SKIP_WIN_MS * `PRSC_CLK_MHZ * 1000,
  parameter integer TIMEOUT_TICKS = `PRSC_TIMEOUT_LCO
)
(
  input wire REF_CLK,
  input wire ARST_N,
  input wire REF_IN,
  input wire REG_WR,
  input wire REG_RD,
  input wire [7:0] REG_ADDR,
  input wire [7:0] REG_WDATA,
  output reg [7:0] REG_RDATA,
  output reg [31:0] EFFECTIVE_RATIO,
  output reg RATIO_FORMAT_HIRES,
  output reg LOOP_BW_WIDE,
  output reg [2:0] LOOP_BW_SEL,
  output reg LOCKED,
  output reg CLK_OUT_ENABLE
);

  localparam [1:0] ST_ACQ = 2'h0;
  localparam [1:0] ST_LOCK = 2'h1;
  localparam [1:0] ST_LOST = 2'h2;

  // Shortest period (in clocks) at which skipping is still meaningful
  localparam integer SKIP_MIN_PERIOD = (`PRSC_CLK_MHZ * 1000) / `PRSC_SKIP_MAX_KHZ;

  // Ratio byte decode: bit 2 flags a hit, bits 1:0 give the byte, 3 is the top byte
  function [2:0] ratio_slot;
    input [7:0] a;
    begin
      if (a == `PRSC_ADDR_RATIO3)
        ratio_slot = 3'h7;
      else if (a == `PRSC_ADDR_RATIO2)
        ratio_slot = 3'h6;
      else if (a == `PRSC_ADDR_RATIO1)
        ratio_slot = 3'h5;
      else if (a == `PRSC_ADDR_RATIO0)
        ratio_slot = 3'h4;
      else
        ratio_slot = 3'h0;
    end
  endfunction

  reg [31:0] ratio_q;
  reg [31:0] ratio_d;
  reg skip_q;
  reg skip_d;
  reg outunl_q;
  reg outunl_d;
  reg fmt_q;
  reg fmt_d;
  reg [2:0] bw_q;
  reg [2:0] bw_d;
  reg [2:0] scale_q;
  reg [2:0] scale_d;
  reg relock_q;
  reg [2:0] wr_slot;
  reg [2:0] rd_slot;
  reg [7:0] rdata_d;

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg ref_prev_q;
  reg [23:0] gap_q;
  reg [23:0] gap_d;
  reg [23:0] period_q;
  reg [23:0] period_d;
  reg [3:0] acq_q;
  reg [3:0] acq_d;
  reg [3:0] lco_div_q;
  reg [23:0] lco_cnt_q;
  reg [23:0] lco_cnt_d;
  reg period_valid_q;
  reg period_valid_d;

  wire ref_edge;
  wire lco_tick;
  wire [24:0] tol;
  wire [24:0] gap_ext;
  wire [24:0] per_lo;
  wire [24:0] per_hi;
  wire is_short;
  wire is_long;
  wire skip_ok;
  wire in_window;
  wire timed_out;
  wire [31:0] scaled_ratio;

  // Register writes; configuration lives at byte offsets next to the ratio
  always @*
  begin
    ratio_d = ratio_q;
    skip_d = skip_q;
    outunl_d = outunl_q;
    fmt_d = fmt_q;
    bw_d = bw_q;
    scale_d = scale_q;
    wr_slot = ratio_slot(REG_ADDR);
    if (REG_WR)
    begin
      if (wr_slot[2])
      begin
        case (wr_slot[1:0])
          2'h3: ratio_d[31:24] = REG_WDATA;
          2'h2: ratio_d[23:16] = REG_WDATA;
          2'h1: ratio_d[15:8] = REG_WDATA;
          default: ratio_d[7:0] = REG_WDATA;
        endcase
      end
      else if (REG_ADDR == `PRSC_ADDR_CFG)
      begin
        skip_d = REG_WDATA[`PRSC_CFG_SKIP_BIT];
        outunl_d = REG_WDATA[`PRSC_CFG_OUTUNL_BIT];
        fmt_d = REG_WDATA[`PRSC_CFG_FMT_BIT];
        bw_d = REG_WDATA[`PRSC_CFG_BW_MSB:`PRSC_CFG_BW_LSB];
      end
      else if (REG_ADDR == `PRSC_ADDR_SCALE)
      begin
        scale_d = REG_WDATA[`PRSC_SCALE_MSB:`PRSC_SCALE_LSB];
      end
    end
  end

  // Read data; unmapped offsets read zero
  always @*
  begin
    rdata_d = 8'h00;
    rd_slot = ratio_slot(REG_ADDR);
    if (rd_slot[2])
    begin
      case (rd_slot[1:0])
        2'h3: rdata_d = ratio_q[31:24];
        2'h2: rdata_d = ratio_q[23:16];
        2'h1: rdata_d = ratio_q[15:8];
        default: rdata_d = ratio_q[7:0];
      endcase
    end
    else if (REG_ADDR == `PRSC_ADDR_CFG)
    begin
      rdata_d[`PRSC_CFG_SKIP_BIT] = skip_q;
      rdata_d[`PRSC_CFG_OUTUNL_BIT] = outunl_q;
      rdata_d[`PRSC_CFG_FMT_BIT] = fmt_q;
      rdata_d[`PRSC_CFG_BW_MSB:`PRSC_CFG_BW_LSB] = bw_q;
    end
    else if (REG_ADDR == `PRSC_ADDR_SCALE)
    begin
      rdata_d[`PRSC_SCALE_MSB:`PRSC_SCALE_LSB] = scale_q;
    end
    else if (REG_ADDR == `PRSC_ADDR_STATUS)
    begin
      rdata_d[`PRSC_STAT_LOCK_BIT] = (state_q == ST_LOCK);
      rdata_d[`PRSC_STAT_ACQ_BIT] = (state_q == ST_ACQ);
      rdata_d[`PRSC_STAT_LOST_BIT] = (state_q == ST_LOST);
    end
  end

  always @(posedge REF_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      ratio_q <= `PRSC_RATIO_RST;
      skip_q <= `PRSC_SKIP_RST;
      outunl_q <= `PRSC_OUTUNL_RST;
      fmt_q <= `PRSC_FMT_RST;
      bw_q <= `PRSC_BW_RST;
      scale_q <= `PRSC_SCALE_RST;
      relock_q <= 1'b0;
      REG_RDATA <= 8'h00;
    end
    else
    begin
      ratio_q <= ratio_d;
      skip_q <= skip_d;
      outunl_q <= outunl_d;
      fmt_q <= fmt_d;
      bw_q <= bw_d;
      scale_q <= scale_d;
      // Only a real change of the synthesizer value drops lock; rewriting the same value is harmless
      relock_q <= (ratio_d != ratio_q) | (fmt_d != fmt_q) | (scale_d != scale_q);
      if (REG_RD)
        REG_RDATA <= rdata_d;
    end
  end

  prsc_ratio_scale u_scale
  (
    .user_ratio(ratio_q),
    .ratio_scale_sel(scale_q),
    .effective_ratio(scaled_ratio)
  );

  // Oscillator tick that paces the long time-out
  assign lco_tick = (lco_div_q == `PRSC_LCO_DIV_MAX);
  assign ref_edge = REF_IN & ~ref_prev_q;

  // Period tolerance of one eighth absorbs input jitter
  assign tol = {4'h0, period_q[23:3]};
  assign gap_ext = {1'b0, gap_q};
  assign per_lo = {1'b0, period_q} - tol;
  assign per_hi = {1'b0, period_q} + tol;
  assign is_short = period_valid_q & (gap_ext < per_lo);
  assign is_long = period_valid_q & (gap_ext > per_hi);
  assign skip_ok = skip_q & ({8'h00, period_q} >= SKIP_MIN_PERIOD);
  assign in_window = ({8'h00, gap_q} <= SKIP_WIN_CYCLES);
  assign timed_out = lco_tick & ({8'h00, lco_cnt_q} >= TIMEOUT_TICKS - 1);

  always @*
  begin
    state_d = state_q;
    gap_d = (gap_q == `PRSC_GAP_SAT) ? gap_q : gap_q + 24'h00_0001;
    period_d = period_q;
    period_valid_d = period_valid_q;
    acq_d = acq_q;
    lco_cnt_d = lco_tick ? lco_cnt_q + 24'h00_0001 : lco_cnt_q;
    if (ref_edge)
    begin
      gap_d = 24'h00_0001;
      lco_cnt_d = 24'h00_0000;
    end
    case (state_q)
      ST_ACQ:
      begin
        if (ref_edge)
        begin
          period_d = gap_q;
          period_valid_d = 1'b1;
          if (is_short | is_long | ~period_valid_q)
            acq_d = 4'h0;
          else if (acq_q != `PRSC_ACQ_EDGES)
            acq_d = acq_q + 4'h1;
          else if (ratio_q != 32'h0000_0000)
            state_d = ST_LOCK;
        end
        else if (timed_out)
        begin
          state_d = ST_LOST;
          period_valid_d = 1'b0;
        end
      end
      ST_LOCK:
      begin
        if (ref_edge)
        begin
          if (is_short)
          begin
            state_d = ST_ACQ;
            acq_d = 4'h0;
            period_d = gap_q;
          end
          else if (is_long)
          begin
            // A skipped gap keeps the old period as the reference for the next edge
            if (skip_ok & in_window)
              state_d = ST_LOCK;
            else if (skip_ok)
              state_d = ST_LOCK;
            else
            begin
              state_d = ST_ACQ;
              acq_d = 4'h0;
            end
          end
          else
            period_d = gap_q;
        end
        else if (timed_out)
        begin
          state_d = ST_LOST;
          period_valid_d = 1'b0;
        end
      end
      ST_LOST:
      begin
        if (ref_edge)
        begin
          state_d = ST_ACQ;
          acq_d = 4'h0;
        end
      end
      default:
        state_d = ST_ACQ;
    endcase
    // A new synthesizer value restarts acquisition from the current period
    if (relock_q & (state_d == ST_LOCK))
    begin
      state_d = ST_ACQ;
      acq_d = 4'h0;
    end
  end

  always @(posedge REF_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      state_q <= ST_ACQ;
      ref_prev_q <= 1'b0;
      gap_q <= 24'h00_0000;
      period_q <= 24'h00_0000;
      period_valid_q <= 1'b0;
      acq_q <= 4'h0;
      lco_div_q <= 4'h0;
      lco_cnt_q <= 24'h00_0000;
    end
    else
    begin
      state_q <= state_d;
      ref_prev_q <= REF_IN;
      gap_q <= gap_d;
      period_q <= period_d;
      period_valid_q <= period_valid_d;
      acq_q <= acq_d;
      lco_div_q <= lco_tick ? 4'h0 : lco_div_q + 4'h1;
      lco_cnt_q <= lco_cnt_d;
    end
  end

  // Outputs to the synthesizer and loop filter, all registered
  always @(posedge REF_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      EFFECTIVE_RATIO <= 32'h0000_0000;
      RATIO_FORMAT_HIRES <= `PRSC_FMT_RST;
      LOOP_BW_WIDE <= 1'b1;
      LOOP_BW_SEL <= `PRSC_BW_RST;
      LOCKED <= 1'b0;
      CLK_OUT_ENABLE <= 1'b0;
    end
    else
    begin
      EFFECTIVE_RATIO <= scaled_ratio;
      // High means 12.20 integer/fraction split, low means 20.12
      RATIO_FORMAT_HIRES <= fmt_q;
      LOOP_BW_WIDE <= (state_q != ST_LOCK);
      // Corner code drives the loop filter; wander below it passes through
      LOOP_BW_SEL <= bw_q;
      LOCKED <= (state_q == ST_LOCK);
      // Output keeps running through an outage until the time-out drops the lock
      CLK_OUT_ENABLE <= (state_q == ST_LOCK) | outunl_q;
    end
  end

endmodule

// ---- sim/prsc_ref_src.sv ----
// Reference clock source model with settable period and pulse muting
`timescale 1ns/1ps
module prsc_ref_src
(
  input wire clk,
  input wire rst_n,
  input wire mute,
  input wire [15:0] period,
  output reg ref_out
);
  reg [15:0] cnt_q;
  wire wrap = cnt_q >= period - 16'h0001;
  // Counter runs on while muted, so pulses come back on the old grid
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= 16'h0000;
      ref_out <= 1'b0;
    end
    else
    begin
      cnt_q <= wrap ? 16'h0000 : cnt_q + 16'h0001;
      ref_out <= #1 wrap && !mute;
    end
  end
endmodule

// ---- sim/prsc_top_properties.sv ----
// Port-level assertions for the reference skip and ratio control block
`timescale 1ns/1ps
module prsc_top_props
#(
  parameter integer TIMEOUT_TICKS = 8388608
)
(
  input wire REF_CLK,
  input wire ARST_N,
  input wire REF_IN,
  input wire REG_WR,
  input wire REG_RD,
  input wire [7:0] REG_ADDR,
  input wire [7:0] REG_WDATA,
  input wire [7:0] REG_RDATA,
  input wire [31:0] EFFECTIVE_RATIO,
  input wire RATIO_FORMAT_HIRES,
  input wire LOOP_BW_WIDE,
  input wire [2:0] LOOP_BW_SEL,
  input wire LOCKED,
  input wire CLK_OUT_ENABLE
);
  localparam integer TO_CYC = 16 * TIMEOUT_TICKS;
  reg [31:0] ratio_q, gap_q;
  reg [7:0] cfg_q, rd_q;
  reg [2:0] scale_q;
  reg [1:0] quiet_q;
  reg ref_q;
  wire in_ratio = REG_ADDR >= 8'h06 && REG_ADDR <= 8'h09;
  wire [7:0] cur_byte = ratio_q[(8'h09 - REG_ADDR) * 8 +: 8];
  wire [31:0] eff_exp = scale_q[2] ? ratio_q >> ({1'b0, scale_q[1:0]} + 3'h1) : ratio_q << scale_q[1:0];
  // Quiet means no write for three edges, so registered outputs have settled
  wire low_idle = cfg_q[1:0] == 2'h0 && quiet_q == 2'h3;
  always @(posedge REF_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      {ratio_q, gap_q, cfg_q, rd_q, scale_q, quiet_q, ref_q} <= 86'h0;
    end
    else
    begin
      ref_q <= REF_IN;
      gap_q <= (REF_IN && !ref_q) ? 32'h0 : gap_q + {31'h0, gap_q != 32'hFFFF_FFFF};
      quiet_q <= REG_WR ? 2'h0 : quiet_q + {1'b0, quiet_q != 2'h3};
      rd_q <= cur_byte;
      if (REG_WR && in_ratio)
        ratio_q[(8'h09 - REG_ADDR) * 8 +: 8] <= REG_WDATA;
      if (REG_WR && REG_ADDR == 8'h0A)
        cfg_q <= REG_WDATA;
      if (REG_WR && REG_ADDR == 8'h0B)
        scale_q <= REG_WDATA[2:0];
    end
  end
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!ARST_N);
  eff_ratio_a: assert property (quiet_q == 2'h3 |-> EFFECTIVE_RATIO == eff_exp)
    else $error("effective ratio wrong");
  ratio_format_a: assert property (quiet_q == 2'h3 |-> RATIO_FORMAT_HIRES == cfg_q[2])
    else $error("ratio format wrong");
  bw_select_a: assert property (quiet_q == 2'h3 |-> LOOP_BW_SEL == cfg_q[6:4])
    else $error("bandwidth select wrong");
  ratio_readback_a: assert property (REG_RD && in_ratio |=> REG_RDATA == rd_q)
    else $error("ratio byte read wrong");
  bw_narrow_a: assert property (LOCKED && $past(LOCKED) |-> !LOOP_BW_WIDE)
    else $error("wide bandwidth while locked");
  bw_widen_a: assert property ($fell(LOCKED) |-> ##[0:2] LOOP_BW_WIDE)
    else $error("bandwidth not widened");
  out_locked_a: assert property (LOCKED && $past(LOCKED) |-> CLK_OUT_ENABLE)
    else $error("output stopped while locked");
  out_unlock_a: assert property (!LOCKED && !$past(LOCKED) && low_idle |-> !CLK_OUT_ENABLE)
    else $error("output runs while unlocked");
  hold_timeout_a: assert property ($fell(LOCKED) && quiet_q == 2'h3 && cfg_q[0] |-> gap_q < 8 || gap_q >= TO_CYC - 32)
    else $error("unlock before time-out");
  timeout_unlock_a: assert property (gap_q == TO_CYC + 48 |-> !LOCKED)
    else $error("no unlock after time-out");
  ratio_relock_a: assert property (REG_WR && in_ratio && LOCKED && REG_WDATA != cur_byte |-> ##[1:4] !LOCKED)
    else $error("ratio change kept lock");
  lock_seen_c: cover property ($rose(LOCKED));
  timeout_seen_c: cover property (gap_q == TO_CYC && !LOCKED);
  skip_hold_c: cover property (cfg_q[0] && LOCKED && gap_q == 6000);
endmodule
bind prsc_top prsc_top_props #(.TIMEOUT_TICKS(TIMEOUT_TICKS)) u_prsc_top_props (.REF_CLK(REF_CLK), .ARST_N(ARST_N),
  .REF_IN(REF_IN), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
  .REG_RDATA(REG_RDATA), .EFFECTIVE_RATIO(EFFECTIVE_RATIO), .RATIO_FORMAT_HIRES(RATIO_FORMAT_HIRES),
  .LOOP_BW_WIDE(LOOP_BW_WIDE), .LOOP_BW_SEL(LOOP_BW_SEL), .LOCKED(LOCKED), .CLK_OUT_ENABLE(CLK_OUT_ENABLE));

// ---- sim/tb_top.sv ----
// Self-checking bench for the reference skip and ratio control block
`timescale 1ns/1ps
module tb_top;
  localparam integer TO_T = 512;
  reg REF_CLK = 1'b0, ARST_N = 1'b0, REG_WR = 1'b0, REG_RD = 1'b0, mute = 1'b1;
  reg [7:0] REG_ADDR = 8'h00, REG_WDATA = 8'h00, cfg_m = 8'h00;
  reg [15:0] period = 16'h0064;
  reg [31:0] seed = 32'h7B3F, ratio_m = 32'h0;
  reg [2:0] scale_m = 3'h0;
  wire REF_IN, RATIO_FORMAT_HIRES, LOOP_BW_WIDE, LOCKED, CLK_OUT_ENABLE;
  wire [7:0] REG_RDATA;
  wire [31:0] EFFECTIVE_RATIO;
  wire [2:0] LOOP_BW_SEL;
  integer miscompares = 0, n_tests = 0, cyc = 0, drops = 0, i;
  prsc_ref_src u_prsc_ref_src (.clk(REF_CLK), .rst_n(ARST_N), .mute(mute), .period(period), .ref_out(REF_IN));
  prsc_top #(.SKIP_WIN_CYCLES(2000), .TIMEOUT_TICKS(TO_T)) u_prsc_top (.REF_CLK(REF_CLK), .ARST_N(ARST_N),
    .REF_IN(REF_IN), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_RDATA(REG_RDATA), .EFFECTIVE_RATIO(EFFECTIVE_RATIO), .RATIO_FORMAT_HIRES(RATIO_FORMAT_HIRES),
    .LOOP_BW_WIDE(LOOP_BW_WIDE), .LOOP_BW_SEL(LOOP_BW_SEL), .LOCKED(LOCKED), .CLK_OUT_ENABLE(CLK_OUT_ENABLE));
  always #2 REF_CLK = ~REF_CLK;
  always @(posedge REF_CLK)
  begin
    cyc = cyc + 1;
    if (LOCKED !== 1'b1 || CLK_OUT_ENABLE !== 1'b1)
      drops = drops + 1;
    if (cyc == 100000)
    begin
      miscompares = miscompares + 1;
      $display("Error at %0t: run hung", $time);
      end_sim;
    end
  end
  function [31:0] xs(input [31:0] s);
  begin
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    xs = s ^ (s << 5);
  end
  endfunction
  // Modifier as a true product, kept apart from any shift form
  function [31:0] mdl_eff(input [2:0] s);
  begin
    mdl_eff = s < 4 ? ratio_m * (32'h1 << s) : ratio_m / (32'h1 << (s - 3'h3));
  end
  endfunction
  task end_sim;
  begin
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  end
  endtask
  task check(input logic [31:0] got, input logic [31:0] exp);
  begin
    n_tests = n_tests + 1;
    if (got !== exp)
    begin
      miscompares = miscompares + 1;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask
  task wr(input [7:0] a, input [7:0] d);
  begin
    @(posedge REF_CLK);
    #1;
    {REG_WR, REG_ADDR, REG_WDATA} = {1'b1, a, d};
    if (a >= 8'h06 && a <= 8'h09)
      ratio_m[(8'h09 - a) * 8 +: 8] = d;
    if (a == 8'h0A)
      cfg_m = d;
    if (a == 8'h0B)
      scale_m = d[2:0];
    @(posedge REF_CLK);
    #1;
    REG_WR = 1'b0;
  end
  endtask
  task rd(input [7:0] a, input [7:0] e);
  begin
    @(posedge REF_CLK);
    #1;
    {REG_RD, REG_ADDR} = {1'b1, a};
    @(posedge REF_CLK);
    #1;
    REG_RD = 1'b0;
    check({24'h0, REG_RDATA}, {24'h0, e});
  end
  endtask
  task wait_lock(input logic v, input integer lim);
    integer k;
  begin
    k = 0;
    while (LOCKED !== v && k < lim)
    begin
      @(posedge REF_CLK);
      #1;
      k = k + 1;
    end
    @(posedge REF_CLK);
    #1;
    check({31'h0, LOCKED}, {31'h0, v});
  end
  endtask
  task settle;
  begin
    repeat (3) @(posedge REF_CLK);
    #1;
  end
  endtask
  initial
  begin
    repeat (12) @(posedge REF_CLK);
    #1;
    ARST_N = 1'b1;
    for (i = 6; i < 12; i = i + 1)
      rd(i[7:0], 8'h00);
    rd(8'h20, 8'h00);
    check({30'h0, RATIO_FORMAT_HIRES, LOOP_BW_WIDE}, 32'h1);
    check({30'h0, LOCKED, CLK_OUT_ENABLE}, 32'h0);
    $display("test reset done");
    // Top bits clear and low nibble zero so no modifier overflows or truncates
    seed = xs(seed);
    seed = (seed & 32'h1FFF_FFF0) | 32'h0000_0100;
    for (i = 0; i < 4; i = i + 1)
      wr(8'h06 + i[7:0], seed[8 * (3 - i) +: 8]);
    for (i = 0; i < 8; i = i + 1)
    begin
      wr(8'h0B, {5'h00, i[2:0]});
      wr(8'h0A, {1'b0, i[2:0], 1'b0, i[0], 2'h0});
      settle;
      check(EFFECTIVE_RATIO, mdl_eff(scale_m));
      check({28'h0, RATIO_FORMAT_HIRES, LOOP_BW_SEL}, {28'h0, i[0], i[2:0]});
      rd(8'h06 + {6'h00, i[1:0]}, ratio_m[8 * (3 - i[1:0]) +: 8]);
    end
    $display("test ratio done");
    mute = 1'b0;
    wait_lock(1'b1, 4000);
    check({30'h0, LOOP_BW_WIDE, CLK_OUT_ENABLE}, 32'h1);
    rd(8'h0C, 8'h01);
    period = 16'h003C;
    wait_lock(1'b0, 300);
    check({30'h0, LOOP_BW_WIDE, CLK_OUT_ENABLE}, 32'h2);
    period = 16'h0064;
    wait_lock(1'b1, 6000);
    wr(8'h09, ratio_m[7:0] ^ 8'h10);
    wait_lock(1'b0, 5);
    check(EFFECTIVE_RATIO, mdl_eff(scale_m));
    wait_lock(1'b1, 6000);
    // Skip is off here, and the outage is far shorter than the window, so lock drops on return
    @(posedge REF_IN);
    mute = 1'b1;
    repeat (150) @(posedge REF_CLK);
    #1;
    mute = 1'b0;
    check({30'h0, LOCKED, CLK_OUT_ENABLE}, 32'h3);
    wait_lock(1'b0, 100);
    rd(8'h0C, 8'h02);
    wait_lock(1'b1, 6000);
    $display("test lock done");
    wr(8'h0A, cfg_m | 8'h03);
    @(posedge REF_IN);
    mute = 1'b1;
    repeat (16 * TO_T - 300) @(posedge REF_CLK);
    #1;
    check({31'h0, LOCKED}, 32'h1);
    wait_lock(1'b0, 500);
    check({31'h0, CLK_OUT_ENABLE}, 32'h1);
    rd(8'h0C, 8'h04);
    wr(8'h0A, cfg_m & 8'hFD);
    settle;
    check({31'h0, CLK_OUT_ENABLE}, 32'h0);
    period = 16'h0C35;
    mute = 1'b0;
    repeat (20) @(posedge REF_CLK);
    #1;
    check({31'h0, LOCKED}, 32'h0);
    wait_lock(1'b1, 70000);
    $display("test timeout done");
    // One missed pulse: longer than the skip window, well inside the time-out
    @(posedge REF_IN);
    mute = 1'b1;
    drops = 0;
    repeat (3200) @(posedge REF_CLK);
    #1;
    mute = 1'b0;
    repeat (3200) @(posedge REF_CLK);
    #1;
    check(drops, 0);
    check({31'h0, LOCKED}, 32'h1);
    $display("test skip done");
    end_sim;
  end
endmodule
